/* core/uis_pkg.sv */
// Package of register map, field positions and reset values for the interrupt status block.
package uis_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses).
	// ----------------------------------------------------------------
	localparam logic [11:0] UIS_TRIG_SEL_OFFSET   = 12'h034;
	localparam logic [11:0] UIS_MASK_OFFSET       = 12'h038;
	localparam logic [11:0] UIS_RAW_STATE_OFFSET  = 12'h03c;
	localparam logic [11:0] UIS_MASKED_OFFSET     = 12'h040;
	localparam logic [11:0] UIS_CLEAR_OFFSET      = 12'h044;
	localparam logic [11:0] UIS_IDENT_FOUR_OFFSET = 12'hfd0;

	// ----------------------------------------------------------------
	// Field positions and widths.
	// ----------------------------------------------------------------
	localparam int UIS_NUM_SRC      = 7;
	localparam int UIS_SRC_LSB      = 4;
	localparam int UIS_SRC_MSB      = 10;
	localparam int UIS_BIT_RX       = 0;
	localparam int UIS_BIT_TX       = 1;
	localparam int UIS_BIT_RTO      = 2;
	localparam int UIS_BIT_FRAMING  = 3;
	localparam int UIS_BIT_PARITY   = 4;
	localparam int UIS_BIT_BREAK    = 5;
	localparam int UIS_BIT_OVERRUN  = 6;
	localparam int UIS_LEVEL_W      = 5;
	localparam int UIS_SEL_W        = 3;
	localparam int UIS_RX_SEL_LSB   = 3;
	localparam int UIS_TX_SEL_LSB   = 0;

	// ----------------------------------------------------------------
	// Reset and fixed values.
	// ----------------------------------------------------------------
	localparam logic [3:0] UIS_RAW_LOW_RESET          = 4'hf;
	localparam logic [UIS_NUM_SRC-1:0] UIS_MASK_RESET = 7'h00;
	localparam logic [5:0] UIS_TRIG_SEL_RESET         = 6'h12;
	// Identification byte value is arbitrary.
	localparam logic [7:0] UIS_IDENT_BYTE             = 8'h5a;

	// Trigger level in FIFO entries for a 16-deep FIFO, index by select code.
	localparam logic [UIS_LEVEL_W-1:0] UIS_LVL_1_8 = 5'h02;
	localparam logic [UIS_LEVEL_W-1:0] UIS_LVL_1_4 = 5'h04;
	localparam logic [UIS_LEVEL_W-1:0] UIS_LVL_1_2 = 5'h08;
	localparam logic [UIS_LEVEL_W-1:0] UIS_LVL_3_4 = 5'h0c;
	localparam logic [UIS_LEVEL_W-1:0] UIS_LVL_7_8 = 5'h0e;

endpackage

/* core/uis_flag.sv */
// One sticky interrupt flag: event sets, write-one clears, set wins.
module uis_flag (
	input  wire logic clk_sys_in,
	input  wire logic rst_n_in,
	input  wire logic en_in,
	input  wire logic set_in,
	input  wire logic clr_in,
	output logic      flag_out
);
	typedef struct packed {
		logic flag;
	} uis_flag_s;

	uis_flag_s st_reg;
	uis_flag_s st_next;

	// Set has priority over a clear in the same cycle.
	always_comb begin
		st_next = st_reg;
		if (set_in) begin
			st_next.flag = 1'b1;
		end else if (clr_in) begin
			st_next.flag = 1'b0;
		end
	end

	// State register.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_reg <= '0;
		end else if (en_in) begin
			st_reg <= st_next;
		end
	end

	assign flag_out = st_reg.flag;
endmodule

/* core/uis_cross.sv */
// Detects the FIFO fill level passing through a trigger level.
module uis_cross (
	input  wire logic                        clk_sys_in,
	input  wire logic                        rst_n_in,
	input  wire logic                        en_in,
	input  wire logic                        rising_in,
	input  wire logic [uis_pkg::UIS_LEVEL_W-1:0] level_in,
	input  wire logic [uis_pkg::UIS_LEVEL_W-1:0] trig_in,
	output logic                             cross_out
);
	import uis_pkg::*;

	typedef struct packed {
		logic [UIS_LEVEL_W-1:0] prev;
	} uis_cross_s;

	uis_cross_s st_reg;
	uis_cross_s st_next;
	logic       now_hit;
	logic       was_hit;

	// Crossing is a change from not reaching to reaching the trigger.
	always_comb begin
		st_next      = st_reg;
		st_next.prev = level_in;
		if (rising_in) begin
			now_hit = level_in >= trig_in;
			was_hit = st_reg.prev >= trig_in;
		end else begin
			now_hit = level_in <= trig_in;
			was_hit = st_reg.prev <= trig_in;
		end
		cross_out = en_in && now_hit && !was_hit;
	end

	// Previous level register.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_reg <= '0;
		end else if (en_in) begin
			st_reg <= st_next;
		end
	end
endmodule

/* core/uis_top.sv */
// Interrupt status, mask and clear logic of a serial port, with register port.
//
// Decided for this implementation: the plain strobed port.
module uis_top (
	input  wire logic                        clk_sys_in,
	input  wire logic                        rst_n_in,
	input  wire logic                        clk_en_in,
	input  wire logic [11:0]                 addr_in,
	input  wire logic [31:0]                 wdata_in,
	input  wire logic                        wr_in,
	input  wire logic                        rd_in,
	output logic      [31:0]                 rdata_out,
	input  wire logic                        overrun_evt_in,
	input  wire logic                        break_evt_in,
	input  wire logic                        parity_evt_in,
	input  wire logic                        framing_evt_in,
	input  wire logic                        rx_timeout_evt_in,
	input  wire logic [uis_pkg::UIS_LEVEL_W-1:0] tx_level_in,
	input  wire logic [uis_pkg::UIS_LEVEL_W-1:0] rx_level_in,
	output logic                             irq_out
);
	import uis_pkg::*;

	// ----------------------------------------------------------------
	// State.
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [UIS_NUM_SRC-1:0] irq_mask_register;
		logic [5:0]             fifo_trigger_select_register;
		logic [31:0]            rdata;
		logic                   irq;
	} uis_top_s;

	uis_top_s st_reg;
	uis_top_s st_next;

	logic [UIS_NUM_SRC-1:0] set_vec;
	logic [UIS_NUM_SRC-1:0] clr_vec;
	logic [UIS_NUM_SRC-1:0] raw_vec;
	logic [UIS_NUM_SRC-1:0] masked_vec;
	logic [UIS_LEVEL_W-1:0] tx_trig;
	logic [UIS_LEVEL_W-1:0] rx_trig;
	logic                   tx_cross;
	logic                   rx_cross;

	// ----------------------------------------------------------------
	// Trigger level decode.
	// ----------------------------------------------------------------

	// Maps a select code to a FIFO level; reserved codes act as half full.
	function automatic logic [UIS_LEVEL_W-1:0] uis_level(input logic [UIS_SEL_W-1:0] sel);
		case (sel)
			3'h0: uis_level = UIS_LVL_1_8;
			3'h1: uis_level = UIS_LVL_1_4;
			3'h2: uis_level = UIS_LVL_1_2;
			3'h3: uis_level = UIS_LVL_3_4;
			3'h4: uis_level = UIS_LVL_7_8;
			default: uis_level = UIS_LVL_1_2;
		endcase
	endfunction

	// Trigger levels from the select register.
	always_comb begin
		tx_trig = uis_level(st_reg.fifo_trigger_select_register[UIS_TX_SEL_LSB +: UIS_SEL_W]);
		rx_trig = uis_level(st_reg.fifo_trigger_select_register[UIS_RX_SEL_LSB +: UIS_SEL_W]);
	end

	// Transmit flag fires as the level falls through its trigger.
	uis_cross u_tx_cross (
		.clk_sys_in (clk_sys_in),
		.rst_n_in   (rst_n_in),
		.en_in      (clk_en_in),
		.rising_in  (1'b0),
		.level_in   (tx_level_in),
		.trig_in    (tx_trig),
		.cross_out  (tx_cross)
	);

	// Receive flag fires as the level rises through its trigger.
	uis_cross u_rx_cross (
		.clk_sys_in (clk_sys_in),
		.rst_n_in   (rst_n_in),
		.en_in      (clk_en_in),
		.rising_in  (1'b1),
		.level_in   (rx_level_in),
		.trig_in    (rx_trig),
		.cross_out  (rx_cross)
	);

	// ----------------------------------------------------------------
	// Sticky flags.
	// ----------------------------------------------------------------

	// Event and clear vectors in source order, receive at index zero.
	always_comb begin
		set_vec                  = '0;
		set_vec[UIS_BIT_RX]      = rx_cross;
		set_vec[UIS_BIT_TX]      = tx_cross;
		set_vec[UIS_BIT_RTO]     = rx_timeout_evt_in;
		set_vec[UIS_BIT_FRAMING] = framing_evt_in;
		set_vec[UIS_BIT_PARITY]  = parity_evt_in;
		set_vec[UIS_BIT_BREAK]   = break_evt_in;
		set_vec[UIS_BIT_OVERRUN] = overrun_evt_in;
		clr_vec = '0;
		if (wr_in && addr_in == UIS_CLEAR_OFFSET) begin
			clr_vec = wdata_in[UIS_SRC_MSB:UIS_SRC_LSB];
		end
	end

	// One flag cell per source.
	for (genvar i = 0; i < UIS_NUM_SRC; i++) begin : g_flag
		uis_flag u_flag (
			.clk_sys_in (clk_sys_in),
			.rst_n_in   (rst_n_in),
			.en_in      (clk_en_in),
			.set_in     (set_vec[i]),
			.clr_in     (clr_vec[i]),
			.flag_out   (raw_vec[i])
		);
	end

	// Masking gates each raw flag.
	assign masked_vec = raw_vec & st_reg.irq_mask_register;

	// ----------------------------------------------------------------
	// Register port and interrupt line.
	// ----------------------------------------------------------------

	// Writes, read data for the next cycle, and the request line.
	always_comb begin
		st_next       = st_reg;
		st_next.rdata = '0;
		st_next.irq   = |masked_vec;
		if (wr_in) begin
			case (addr_in)
				UIS_MASK_OFFSET: begin
					st_next.irq_mask_register = wdata_in[UIS_SRC_MSB:UIS_SRC_LSB];
				end
				UIS_TRIG_SEL_OFFSET: begin
					st_next.fifo_trigger_select_register = wdata_in[5:0];
				end
				default: begin
					st_next.rdata = '0;  // Status, clear and identity need no store.
				end
			endcase
		end
		if (rd_in) begin
			case (addr_in)
				UIS_RAW_STATE_OFFSET: begin
					st_next.rdata[UIS_SRC_MSB:UIS_SRC_LSB] = raw_vec;
					st_next.rdata[3:0] = UIS_RAW_LOW_RESET;
				end
				UIS_MASKED_OFFSET: begin
					st_next.rdata[UIS_SRC_MSB:UIS_SRC_LSB] = masked_vec;
				end
				UIS_MASK_OFFSET: begin
					st_next.rdata[UIS_SRC_MSB:UIS_SRC_LSB] = st_reg.irq_mask_register;
				end
				UIS_TRIG_SEL_OFFSET: begin
					st_next.rdata[5:0] = st_reg.fifo_trigger_select_register;
				end
				UIS_IDENT_FOUR_OFFSET: begin
					st_next.rdata[7:0] = UIS_IDENT_BYTE;
				end
				default: begin
					st_next.rdata = '0;  // Clear register and unmapped read zero
				end
			endcase
		end
	end

	// State register, frozen while the clock enable is low.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_reg.irq_mask_register            <= UIS_MASK_RESET;
			st_reg.fifo_trigger_select_register <= UIS_TRIG_SEL_RESET;
			st_reg.rdata                        <= '0;
			st_reg.irq                          <= 1'b0;
		end else if (clk_en_in) begin
			st_reg <= st_next;
		end
	end

	assign rdata_out = st_reg.rdata;
	assign irq_out   = st_reg.irq;
endmodule

/* test/uis_top_monitor.sv */
// Checker of register reads and of the request output of the interrupt status block.
module uis_top_monitor (
	input wire logic	clk_sys_in,
	input wire logic	rst_n_in,
	input wire logic	clk_en_in,
	input wire logic [11:0]	addr_in,
	input wire logic [31:0]	wdata_in,
	input wire logic	wr_in,
	input wire logic	rd_in,
	input wire logic [31:0]	rdata_out,
	input wire logic	parity_evt_in,
	input wire logic	irq_out
);
	import uis_pkg::*;
	// ----------------------------------------------------------------
	// Accesses taken at an edge.
	// ----------------------------------------------------------------
	wire rd_raw = rd_in && clk_en_in && addr_in == UIS_RAW_STATE_OFFSET;
	wire rd_msk = rd_in && clk_en_in && addr_in == UIS_MASKED_OFFSET;
	wire rd_id = rd_in && clk_en_in && addr_in == UIS_IDENT_FOUR_OFFSET;
	wire rd_clr = rd_in && clk_en_in && addr_in == UIS_CLEAR_OFFSET;
	wire wr_m0 = wr_in && clk_en_in && addr_in == UIS_MASK_OFFSET && wdata_in[10:4] == 7'h00;
	wire wr_cp = wr_in && clk_en_in && addr_in == UIS_CLEAR_OFFSET && wdata_in[8];
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	// A parity event followed at once by a raw read.
	sequence s_evt_read;
		parity_evt_in && clk_en_in ##1 rd_raw;
	endsequence
	// A parity clear, a quiet cycle, then a raw read, with no parity event throughout.
	sequence s_clr_read;
		wr_cp && !parity_evt_in ##1 clk_en_in && !parity_evt_in ##1 rd_raw && !parity_evt_in;
	endsequence
	a_raw_low_fixed: assert property (rd_raw |=> rdata_out[3:0] == 4'hf)
		else $error("raw status low bits not fixed");
	a_masked_resv_zero: assert property (rd_msk |=> rdata_out[3:0] == 4'h0 && rdata_out[31:11] == 21'h0)
		else $error("masked status reserved bits not zero");
	a_ident_value: assert property (rd_id |=> rdata_out == {24'h0, UIS_IDENT_BYTE})
		else $error("identification read wrong");
	a_clear_reads_zero: assert property (rd_clr |=> rdata_out == 32'h0)
		else $error("clear register read not zero");
	a_event_sets_raw: assert property (s_evt_read |=> rdata_out[8])
		else $error("parity event not seen in raw status");
	a_clear_drops_raw: assert property (s_clr_read |=> !rdata_out[8])
		else $error("parity flag not cleared");
	a_mask_zero_blocks: assert property (wr_m0 ##1 clk_en_in && !wr_in ##1 rd_msk |=> rdata_out[10:4] == 7'h00)
		else $error("masked flag shown with mask off");
	a_irq_off_unmasked: assert property (wr_m0 ##1 clk_en_in |=> !irq_out)
		else $error("request raised with every mask bit off");
endmodule

bind uis_top uis_top_monitor i_mon (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
	.clk_en_in(clk_en_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
	.rd_in(rd_in), .rdata_out(rdata_out), .parity_evt_in(parity_evt_in), .irq_out(irq_out));

/* test/uis_top_tb.sv */
// Self-checking testbench of the interrupt status block.
module uis_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import uis_pkg::*;
	logic			clk_sys_in, rst_n_in, clk_en_in, wr_in, rd_in, irq_out;
	logic [11:0]		addr_in;
	logic [31:0]		wdata_in, rdata_out, r;
	logic [4:0]		evt;
	logic [UIS_LEVEL_W-1:0]	tx_level_in, rx_level_in;
	logic [6:0]		exp_flags, mask;
	int			fails = 0, checks = 0, cycles = 0, i;
	integer			seed = 32'h09a1752b;

	uis_top i_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata_out), .overrun_evt_in(evt[4]), .break_evt_in(evt[3]),
		.parity_evt_in(evt[2]), .framing_evt_in(evt[1]), .rx_timeout_evt_in(evt[0]),
		.tx_level_in(tx_level_in), .rx_level_in(rx_level_in), .irq_out(irq_out));

	// Expected raw status word from the flags the bench believes are set.
	function automatic logic [31:0] raw_exp();
		return {21'h0, exp_flags, 4'hf};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checks++;
		if (seen !== want) begin
			fails++;
			$display("BAD %0t seen %h want %h", $time, seen, want);
		end
	endtask
	// One write cycle, then an idle cycle so no strobe is driven twice in one step.
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_sys_in);
		wr_in <= 1'b0;
		@(posedge clk_sys_in);
	endtask
	// One read cycle; data and request are looked at mid-cycle after it.
	task automatic rd(input logic [11:0] a, input logic [31:0] want);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_sys_in);
		rd_in <= 1'b0;
		@(negedge clk_sys_in);
		check(rdata_out, want);
		check({31'h0, irq_out}, {31'h0, |(exp_flags & mask)});
		@(posedge clk_sys_in);
	endtask
	// One-cycle event pulse, then an immediate raw read.
	task automatic pulse(input logic [4:0] v);
		evt <= v;
		@(posedge clk_sys_in);
		evt <= 5'h0;
		exp_flags[6:2] = exp_flags[6:2] | v;
		rd(UIS_RAW_STATE_OFFSET, raw_exp());
	endtask
	// New fill levels for one edge, then a raw read.
	task automatic lvl(input logic [4:0] tx, input logic [4:0] rx, input logic [6:0] s);
		tx_level_in <= tx;
		rx_level_in <= rx;
		@(posedge clk_sys_in);
		exp_flags = exp_flags | s;
		rd(UIS_RAW_STATE_OFFSET, raw_exp());
	endtask
	task automatic wrap_up();
		if (fails == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Free-running system clock.
	initial begin
		clk_sys_in = 1'b0;
		forever #5 clk_sys_in = ~clk_sys_in;
	end
	// Watchdog against a hung run.
	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			wrap_up();
		end
	end
	// Main sequence: reset values, refused writes, events, levels, random clears.
	initial begin
		{rst_n_in, wr_in, rd_in, evt, addr_in, wdata_in} = '0;
		{tx_level_in, rx_level_in, exp_flags, mask} = '0;
		clk_en_in = 1'b1;
		repeat (2) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		@(posedge clk_sys_in);
		rd(UIS_RAW_STATE_OFFSET, 32'hf);
		rd(UIS_MASKED_OFFSET, 32'h0);
		rd(UIS_CLEAR_OFFSET, 32'h0);
		rd(12'h800, 32'h0);
		rd(UIS_TRIG_SEL_OFFSET, {26'h0, UIS_TRIG_SEL_RESET});
		wr(UIS_RAW_STATE_OFFSET, 32'h7ff);
		wr(UIS_MASKED_OFFSET, 32'h7ff);
		wr(UIS_IDENT_FOUR_OFFSET, 32'hff);
		wr(UIS_MASK_OFFSET, 32'h0);
		rd(UIS_RAW_STATE_OFFSET, 32'hf);
		rd(UIS_IDENT_FOUR_OFFSET, {24'h0, UIS_IDENT_BYTE});
		for (i = 0; i < 5; i++) pulse(5'h1 << i);
		wr(UIS_MASK_OFFSET, 32'h0);
		rd(UIS_MASKED_OFFSET, 32'h0);
		wr(UIS_MASK_OFFSET, 32'h7f0);
		mask = 7'h7f;
		rd(UIS_MASKED_OFFSET, {21'h0, exp_flags, 4'h0});
		lvl(5'd0, 5'd7, 7'h00);
		lvl(5'd0, 5'd8, 7'h01);
		wr(UIS_CLEAR_OFFSET, 32'h10);
		exp_flags[0] = 1'b0;
		lvl(5'd0, 5'd16, 7'h00);
		lvl(5'd16, 5'd16, 7'h00);
		lvl(5'd9, 5'd16, 7'h00);
		lvl(5'd8, 5'd16, 7'h02);
		// Quarter-full triggers on both sides, then both levels cross them.
		wr(UIS_TRIG_SEL_OFFSET, 32'h9);
		rd(UIS_TRIG_SEL_OFFSET, 32'h9);
		lvl(5'd8, UIS_LVL_1_4 - 5'd1, 7'h00);
		lvl(UIS_LVL_1_4, UIS_LVL_1_4, 7'h03);
		for (i = 0; i < 20; i++) begin
			r = $random(seed);
			wr(UIS_MASK_OFFSET, r & 32'h7f0);
			mask = r[10:4];
			rd(UIS_MASK_OFFSET, r & 32'h7f0);
			wr(UIS_CLEAR_OFFSET, {r[7:0], r[31:8]} & 32'h7f0);
			exp_flags = exp_flags & ~r[18:12];
			pulse(r[24:20]);
			rd(UIS_MASKED_OFFSET, {21'h0, exp_flags & mask, 4'h0});
		end
		// A parity event and its clear in one cycle: the event must win.
		evt <= 5'h04;
		addr_in <= UIS_CLEAR_OFFSET;
		wdata_in <= 32'h100;
		wr_in <= 1'b1;
		@(posedge clk_sys_in);
		evt <= 5'h00;
		wr_in <= 1'b0;
		exp_flags[4] = 1'b1;
		rd(UIS_RAW_STATE_OFFSET, raw_exp());
		wr(UIS_CLEAR_OFFSET, 32'h7f0);
		exp_flags = 7'h00;
		rd(UIS_RAW_STATE_OFFSET, 32'hf);
		// Events while the clock enable is low must leave every flag clear.
		clk_en_in <= 1'b0;
		evt <= 5'h1f;
		repeat (2) @(posedge clk_sys_in);
		clk_en_in <= 1'b1;
		evt <= 5'h00;
		rd(UIS_RAW_STATE_OFFSET, 32'hf);
		wrap_up();
	end
endmodule
